// >>> pmr_pkg.sv
/*
  Constants for the supply-monitor, master-control and first step-down
  converter register bank: byte offsets, field positions, reset values,
  write masks and reset time-out figures.
  Assumes an 8-bit register port and a 25 MHz mclk.
*/
// Operation
// - reset time-out 65 ms if set, else 260 ms
// - action bit 1: low supply raises interrupt
// - action bit 0: low supply shuts down
// - low supply interrupt masked until unmask set
// - low supply flag follows supply comparator
// - four-bit low supply threshold field
// - master-off bit turns every output off
// - button or charger clears master-off bit
// - four spare bits, no effect on operation
// - spare bits cleared on undervoltage lockout
// - select pin low: primary level code used
// - select pin high: secondary level code used
// - enable bit switches converter on and off
// - phase bit selects 180 degree shift
// - mode bit forces fixed-frequency PWM
// - three-bit turn-on delay field
// - fault interrupt passed only when enabled
// - power-good bit follows converter output
// - all bits default on undervoltage lockout
package pmr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_SUPPLY_MON = 8'h00;
  localparam logic [7:0] ADDR_MASTER     = 8'h01;
  localparam logic [7:0] ADDR_PRI_LEVEL  = 8'h20;
  localparam logic [7:0] ADDR_SEC_LEVEL  = 8'h21;
  localparam logic [7:0] ADDR_BUCK_CTRL  = 8'h22;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SM_RST_SEL = 7;
  localparam int SM_ACTION  = 6;
  localparam int SM_UNMASK  = 5;
  localparam int SM_FLAG    = 4;
  localparam int SM_THR_HI  = 3;
  localparam int SM_THR_LO  = 0;
  localparam int MC_OFF     = 5;
  localparam int MC_SPR_HI  = 3;
  localparam int MC_SPR_LO  = 0;
  localparam int LV_HI      = 5;
  localparam int LV_LO      = 0;
  localparam int BC_ON      = 7;
  localparam int BC_PHASE   = 6;
  localparam int BC_MODE    = 5;
  localparam int BC_DLY_HI  = 4;
  localparam int BC_DLY_LO  = 2;
  localparam int BC_FLT     = 1;
  localparam int BC_PG      = 0;

  // ************************************************************
  // reset values and write masks
  // ************************************************************
  localparam logic [7:0] SM_RESET   = 8'h00;
  localparam logic [7:0] MC_RESET   = 8'h00;
  localparam logic [5:0] LV_RESET   = 6'h00;
  localparam logic [7:0] BC_RESET   = 8'h80;
  localparam logic [7:0] SM_WMASK   = 8'hef;
  localparam logic [7:0] MC_WMASK   = 8'hff;
  localparam logic [7:0] BC_WMASK   = 8'hfe;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // ************************************************************
  // reset time-out
  // ************************************************************
  localparam longint RST_SHORT_MS  = 65;
  localparam longint RST_LONG_MS   = 260;
  localparam longint MCLK_HZ       = 25_000_000;
  localparam longint MS_PER_S      = 1000;
  localparam longint RST_SHORT_CYC = RST_SHORT_MS * MCLK_HZ / MS_PER_S;
  localparam longint RST_LONG_CYC  = RST_LONG_MS * MCLK_HZ / MS_PER_S;
  localparam int     RST_CNT_W     = 23;

  typedef enum logic [1:0] {
    RST_HOLD = 2'b01,
    RST_DONE = 2'b10
  } pmr_rst_state_t;

endpackage

// >>> pmr_regs.sv
/*
  Register bank of the power-management controller: supply monitor,
  master control with spare bits, first step-down converter levels and
  control, and the reset-output timer.
  Assumes all inputs are synchronous to mclk, the analog comparators and
  converter are outside, and supply_uvlo is high while the system supply
  is below the lockout level.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module pmr_regs #(
  parameter logic [7:0] SM_DEFAULT  = pmr_pkg::SM_RESET,
  parameter logic [7:0] MC_DEFAULT  = pmr_pkg::MC_RESET,
  parameter logic [5:0] PRI_DEFAULT = pmr_pkg::LV_RESET,
  parameter logic [5:0] SEC_DEFAULT = pmr_pkg::LV_RESET,
  parameter logic [7:0] BC_DEFAULT  = pmr_pkg::BC_RESET,
  parameter int unsigned SHORT_CYC  = 32'(pmr_pkg::RST_SHORT_CYC),
  parameter int unsigned LONG_CYC   = 32'(pmr_pkg::RST_LONG_CYC)
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       low_supply_detect,
  input  wire logic       supply_uvlo,
  input  wire logic       push_button_n,
  input  wire logic       charger_input,
  input  wire logic       level_select_pin,
  input  wire logic       buck_power_good,
  input  wire logic       buck_fault,
  output logic            reset_out_n,
  output logic      [3:0] low_supply_threshold,
  output logic            low_supply_irq,
  output logic            low_supply_shutdown,
  output logic            regulators_off,
  output logic            buck_enable,
  output logic      [5:0] buck_level_code,
  output logic            buck_phase_shift,
  output logic            buck_forced_pwm,
  output logic      [2:0] buck_turn_on_delay,
  output logic            buck_fault_irq
);
  import pmr_pkg::*;

  localparam logic [RST_CNT_W-1:0] LIM_SHORT = RST_CNT_W'(SHORT_CYC - 1);
  localparam logic [RST_CNT_W-1:0] LIM_LONG  = RST_CNT_W'(LONG_CYC - 1);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0]           sm_q;
  logic [7:0]           mc_q;
  logic [5:0]           pri_q;
  logic [5:0]           sec_q;
  logic [7:0]           ctl_q;
  logic                 shut_q;
  logic [RST_CNT_W-1:0] cnt_q;
  logic [RST_CNT_W-1:0] lim;
  pmr_rst_state_t       rst_state_q;
  logic                 wake;
  logic                 clr_all;

  function automatic logic [7:0] wmerge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] mask);
    wmerge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  assign wake    = !push_button_n || charger_input;
  assign clr_all = reset || supply_uvlo;

  // ************************************************************
  // supply monitor register
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (clr_all) begin
      sm_q <= SM_DEFAULT & SM_WMASK;
    end else if (reg_wr && hit(reg_addr, ADDR_SUPPLY_MON)) begin
      sm_q <= wmerge(sm_q, reg_wdata, SM_WMASK);
    end
  end

  // ************************************************************
  // master control register
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (clr_all) begin
      mc_q <= MC_DEFAULT;
    end else begin
      if (reg_wr && hit(reg_addr, ADDR_MASTER)) begin
        mc_q <= wmerge(mc_q, reg_wdata, MC_WMASK);
      end
      if (wake) begin
        mc_q[MC_OFF] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // converter registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (clr_all) begin
      pri_q <= PRI_DEFAULT;
    end else if (reg_wr && hit(reg_addr, ADDR_PRI_LEVEL)) begin
      pri_q <= reg_wdata[LV_HI:LV_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (clr_all) begin
      sec_q <= SEC_DEFAULT;
    end else if (reg_wr && hit(reg_addr, ADDR_SEC_LEVEL)) begin
      sec_q <= reg_wdata[LV_HI:LV_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (clr_all) begin
      ctl_q <= BC_DEFAULT & BC_WMASK;
    end else if (reg_wr && hit(reg_addr, ADDR_BUCK_CTRL)) begin
      ctl_q <= wmerge(ctl_q, reg_wdata, BC_WMASK);
    end
  end

  // ************************************************************
  // low supply shutdown latch
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      shut_q <= 1'b0;
    end else if (low_supply_detect && !sm_q[SM_ACTION]) begin
      shut_q <= 1'b1;
    end else if (wake) begin
      shut_q <= 1'b0;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      if (hit(reg_addr, ADDR_SUPPLY_MON)) begin
        reg_rdata <= {sm_q[7:5], low_supply_detect, sm_q[3:0]};
      end else if (hit(reg_addr, ADDR_MASTER)) begin
        reg_rdata <= mc_q;
      end else if (hit(reg_addr, ADDR_PRI_LEVEL)) begin
        reg_rdata <= {2'h0, pri_q};
      end else if (hit(reg_addr, ADDR_SEC_LEVEL)) begin
        reg_rdata <= {2'h0, sec_q};
      end else if (hit(reg_addr, ADDR_BUCK_CTRL)) begin
        reg_rdata <= {ctl_q[7:1], buck_power_good};
      end else begin
        reg_rdata <= READ_ZERO;
      end
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  // ************************************************************
  // reset output timer
  // ************************************************************
  assign lim = sm_q[SM_RST_SEL] ? LIM_SHORT : LIM_LONG;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_state_q <= RST_HOLD;
      cnt_q       <= '0;
    end else begin
      case (rst_state_q)
        RST_HOLD: begin
          if (!buck_power_good) begin
            cnt_q <= '0;
          end else if (cnt_q >= lim) begin
            rst_state_q <= RST_DONE;
            cnt_q       <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        RST_DONE: begin
          if (!buck_power_good) begin
            rst_state_q <= RST_HOLD;
          end
        end
        default: begin
          rst_state_q <= RST_HOLD;
          cnt_q       <= '0;
        end
      endcase
    end
  end

  assign reset_out_n = (rst_state_q == RST_DONE);

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_supply_threshold <= 4'h0;
      low_supply_irq       <= 1'b0;
      low_supply_shutdown  <= 1'b0;
      regulators_off       <= 1'b0;
      buck_enable          <= 1'b0;
      buck_level_code      <= 6'h00;
      buck_phase_shift     <= 1'b0;
      buck_forced_pwm      <= 1'b0;
      buck_turn_on_delay   <= 3'h0;
      buck_fault_irq       <= 1'b0;
    end else begin
      low_supply_threshold <= sm_q[SM_THR_HI:SM_THR_LO];
      low_supply_irq       <= low_supply_detect && sm_q[SM_ACTION] && sm_q[SM_UNMASK];
      low_supply_shutdown  <= shut_q;
      regulators_off       <= mc_q[MC_OFF] || shut_q;
      buck_enable          <= ctl_q[BC_ON] && !mc_q[MC_OFF] && !shut_q;
      buck_level_code      <= level_select_pin ? sec_q : pri_q;
      buck_phase_shift     <= ctl_q[BC_PHASE];
      buck_forced_pwm      <= ctl_q[BC_MODE];
      buck_turn_on_delay   <= ctl_q[BC_DLY_HI:BC_DLY_LO];
      buck_fault_irq       <= buck_fault && ctl_q[BC_FLT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_timeout_release: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(reset_out_n) |-> ($past(cnt_q) == $past(lim)) && $past(buck_power_good)
  ) else $error("reset output released before time-out");

  a_irq_route: assert property (
    @(posedge mclk) disable iff (reset)
    (low_supply_detect && sm_q[SM_ACTION] && sm_q[SM_UNMASK]) |=> low_supply_irq
  ) else $error("low supply interrupt missing");

  a_low_shutdown: assert property (
    @(posedge mclk) disable iff (reset)
    (low_supply_detect && !sm_q[SM_ACTION] && !wake) |-> ##2 (!buck_enable && regulators_off)
  ) else $error("low supply did not shut outputs down");

  a_irq_masked: assert property (
    @(posedge mclk) disable iff (reset)
    (!sm_q[SM_UNMASK] || !sm_q[SM_ACTION]) |=> !low_supply_irq
  ) else $error("masked low supply interrupt seen");

  a_flag_read: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_rd && hit(reg_addr, ADDR_SUPPLY_MON)) |=> reg_rdata[SM_FLAG] == $past(low_supply_detect)
  ) else $error("low supply flag reads wrong");

  a_master_off: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_wr && hit(reg_addr, ADDR_MASTER) && reg_wdata[MC_OFF] && !wake && !supply_uvlo)
      |-> ##2 (!buck_enable && regulators_off)
  ) else $error("master off did not turn outputs off");

  a_wake_clear: assert property (
    @(posedge mclk) disable iff (reset)
    wake |=> !mc_q[MC_OFF]
  ) else $error("master off not cleared by wake event");

  a_spare_clear: assert property (
    @(posedge mclk) disable iff (reset)
    supply_uvlo |=> mc_q[MC_SPR_HI:MC_SPR_LO] == MC_DEFAULT[MC_SPR_HI:MC_SPR_LO]
  ) else $error("spare bits survived lockout");

  a_level_pick: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 buck_level_code == ($past(level_select_pin) ? $past(sec_q) : $past(pri_q))
  ) else $error("wrong level code chosen");

  a_fault_gate: assert property (
    @(posedge mclk) disable iff (reset)
    (!ctl_q[BC_FLT]) |=> !buck_fault_irq
  ) else $error("fault interrupt passed while disabled");

  a_good_read: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_rd && hit(reg_addr, ADDR_BUCK_CTRL)) |=> reg_rdata[BC_PG] == $past(buck_power_good)
  ) else $error("power-good bit reads wrong");

  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_rd && (hit(reg_addr, ADDR_PRI_LEVEL) || hit(reg_addr, ADDR_SEC_LEVEL)))
      |=> reg_rdata[7:6] == 2'h0
  ) else $error("reserved bits read nonzero");

  a_idle_read: assert property (
    @(posedge mclk) disable iff (reset)
    !reg_rd |=> reg_rdata == READ_ZERO
  ) else $error("read data outside read cycle");

  a_thr_write: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_wr && hit(reg_addr, ADDR_SUPPLY_MON) && !supply_uvlo)
      |=> sm_q[SM_THR_HI:SM_THR_LO] == $past(reg_wdata[SM_THR_HI:SM_THR_LO])
  ) else $error("threshold field not written");

  a_spare_write: assert property (
    @(posedge mclk) disable iff (reset)
    (reg_wr && hit(reg_addr, ADDR_MASTER) && !supply_uvlo)
      |=> mc_q[MC_SPR_HI:MC_SPR_LO] == $past(reg_wdata[MC_SPR_HI:MC_SPR_LO])
  ) else $error("spare bits not written");

  a_enable_gate: assert property (
    @(posedge mclk) disable iff (reset)
    !ctl_q[BC_ON] |=> !buck_enable
  ) else $error("converter enabled while enable bit clear");

  a_phase_mode: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 {buck_phase_shift, buck_forced_pwm} == $past({ctl_q[BC_PHASE], ctl_q[BC_MODE]})
  ) else $error("phase or mode output wrong");

  a_delay_copy: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 buck_turn_on_delay == $past(ctl_q[BC_DLY_HI:BC_DLY_LO])
  ) else $error("turn-on delay output wrong");

  a_lockout_default: assert property (
    @(posedge mclk) disable iff (reset)
    supply_uvlo |=> (pri_q == PRI_DEFAULT) && (sec_q == SEC_DEFAULT)
      && (ctl_q == (BC_DEFAULT & BC_WMASK)) && (sm_q == (SM_DEFAULT & SM_WMASK))
  ) else $error("registers not at default after lockout");

  a_shut_set: assert property (
    @(posedge mclk) disable iff (reset)
    (low_supply_detect && !sm_q[SM_ACTION]) |=> shut_q
  ) else $error("low supply did not set shutdown latch");

endmodule

`default_nettype wire

// >>> test_pmr_regs.sv
/*
  Self-checking bench for the register bank: register port tasks, pin
  stimulus and expected values from the field layout.
  Assumes one 25 MHz mclk and short reset time-out counts of 8 and 32.
*/
`timescale 1ns/1ns
`default_nettype none

module test_pmr_regs;
  import pmr_pkg::*;

  // ************************************************************
  // signals and design
  // ************************************************************
  localparam int SHORT = 8;
  localparam int LONG  = 32;
  logic       mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       low_supply_detect = 0, supply_uvlo = 0, push_button_n = 1;
  logic       charger_input = 0, level_select_pin = 0;
  logic       buck_power_good = 0, buck_fault = 0;
  logic       reset_out_n, low_supply_irq, low_supply_shutdown, regulators_off;
  logic       buck_enable, buck_phase_shift, buck_forced_pwm, buck_fault_irq;
  logic [3:0] low_supply_threshold;
  logic [5:0] buck_level_code;
  logic [2:0] buck_turn_on_delay;
  int         n_errors = 0, compares = 0, cycles = 0;

  pmr_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) DUT (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_supply_detect(low_supply_detect), .supply_uvlo(supply_uvlo),
    .push_button_n(push_button_n), .charger_input(charger_input),
    .level_select_pin(level_select_pin), .buck_power_good(buck_power_good),
    .buck_fault(buck_fault), .reset_out_n(reset_out_n),
    .low_supply_threshold(low_supply_threshold), .low_supply_irq(low_supply_irq),
    .low_supply_shutdown(low_supply_shutdown), .regulators_off(regulators_off),
    .buck_enable(buck_enable), .buck_level_code(buck_level_code),
    .buck_phase_shift(buck_phase_shift), .buck_forced_pwm(buck_forced_pwm),
    .buck_turn_on_delay(buck_turn_on_delay), .buck_fault_irq(buck_fault_irq));

  // ************************************************************
  // clock, timeout and tasks
  // ************************************************************
  initial begin
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic timer(input int lim);
    @(posedge mclk);
    buck_power_good <= 1'b0;
    settle();
    chk(reset_out_n, 1'b0);
    @(posedge mclk);
    buck_power_good <= 1'b1;
    repeat (lim - 1) @(posedge mclk);
    #1;
    chk(reset_out_n, 1'b0);
    @(posedge mclk);
    #1;
    chk(reset_out_n, 1'b1);
  endtask

  task automatic pulse_wake(input bit charger);
    @(posedge mclk);
    if (charger) begin
      charger_input <= 1'b1;
    end else begin
      push_button_n <= 1'b0;
    end
    @(posedge mclk);
    charger_input <= 1'b0;
    push_button_n <= 1'b1;
    settle();
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    settle();
    rd_chk(ADDR_SUPPLY_MON, 8'h00);
    rd_chk(ADDR_MASTER, 8'h00);
    rd_chk(ADDR_PRI_LEVEL, 8'h00);
    rd_chk(ADDR_BUCK_CTRL, 8'h80);
    rd_chk(8'h05, 8'h00);
    chk(buck_enable, 1'b1);
    $display("test defaults done");

    wr(ADDR_PRI_LEVEL, 8'hff);
    wr(ADDR_SEC_LEVEL, 8'hd5);
    rd_chk(ADDR_PRI_LEVEL, 8'h3f);
    rd_chk(ADDR_SEC_LEVEL, 8'h15);
    settle();
    chk(buck_level_code, 8'h3f);
    @(posedge mclk);
    level_select_pin <= 1'b1;
    settle();
    chk(buck_level_code, 8'h15);
    $display("test levels done");

    wr(ADDR_BUCK_CTRL, 8'h77);
    buck_fault <= 1'b1;
    rd_chk(ADDR_BUCK_CTRL, 8'h76);
    settle();
    chk({buck_enable, buck_phase_shift, buck_forced_pwm}, 8'h03);
    chk(buck_turn_on_delay, 8'h05);
    chk(buck_fault_irq, 1'b1);
    wr(ADDR_BUCK_CTRL, 8'h88);
    settle();
    chk({buck_enable, buck_phase_shift, buck_forced_pwm}, 8'h04);
    chk(buck_turn_on_delay, 8'h02);
    chk(buck_fault_irq, 1'b0);
    $display("test converter done");

    timer(LONG);
    rd_chk(ADDR_BUCK_CTRL, 8'h89);
    $display("test long time-out done");

    wr(ADDR_SUPPLY_MON, 8'hf5);
    rd_chk(ADDR_SUPPLY_MON, 8'he5);
    chk(low_supply_threshold, 8'h05);
    @(posedge mclk);
    low_supply_detect <= 1'b1;
    settle();
    rd_chk(ADDR_SUPPLY_MON, 8'hf5);
    chk(low_supply_irq, 1'b1);
    chk(low_supply_shutdown, 1'b0);
    wr(ADDR_SUPPLY_MON, 8'hc5);
    settle();
    chk(low_supply_irq, 1'b0);
    wr(ADDR_SUPPLY_MON, 8'h85);
    settle();
    chk({low_supply_shutdown, regulators_off, buck_enable}, 8'h06);
    @(posedge mclk);
    low_supply_detect <= 1'b0;
    pulse_wake(1'b0);
    chk({low_supply_shutdown, regulators_off, buck_enable}, 8'h01);
    rd_chk(ADDR_SUPPLY_MON, 8'h85);
    $display("test supply monitor done");

    timer(SHORT);
    $display("test short time-out done");

    wr(ADDR_MASTER, 8'h2a);
    rd_chk(ADDR_MASTER, 8'h2a);
    settle();
    chk({regulators_off, buck_enable}, 8'h02);
    pulse_wake(1'b0);
    rd_chk(ADDR_MASTER, 8'h0a);
    chk({regulators_off, buck_enable}, 8'h01);
    wr(ADDR_MASTER, 8'h25);
    pulse_wake(1'b1);
    rd_chk(ADDR_MASTER, 8'h05);
    $display("test master off done");

    @(posedge mclk);
    supply_uvlo <= 1'b1;
    @(posedge mclk);
    supply_uvlo <= 1'b0;
    rd_chk(ADDR_MASTER, 8'h00);
    rd_chk(ADDR_SUPPLY_MON, 8'h00);
    rd_chk(ADDR_SEC_LEVEL, 8'h00);
    rd_chk(ADDR_BUCK_CTRL, 8'h81);
    $display("test lockout done");
    results();
  end
endmodule

`default_nettype wire
